//--- common/zgcs_pkg.sv
package zgcs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHANNEL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SRC = 8'h0C;
  localparam logic [7:0] ADDR_SEQ = 8'h10;
  localparam int CTRL_LIST_LSB = 0;
  localparam int CTRL_BTN_DIS_BIT = 2;
  localparam int CTRL_DECOM_BIT = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MANUAL_BIT = 1;
  localparam int STAT_HELD_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] CH_FIRST = 5'h0B;
  localparam logic [4:0] CH_LAST = 5'h1A;
  localparam logic [4:0] CH_PRI_1 = 5'h0B;
  localparam logic [4:0] CH_PRI_2 = 5'h0F;
  localparam logic [4:0] CH_PRI_3 = 5'h14;
  localparam logic [4:0] CH_PRI_4 = 5'h19;
  localparam logic [7:0] DECOM_FC = 8'h8C;
  localparam logic [7:0] DECOM_EXT_FC = 8'h30;
  localparam logic [7:0] DECOM_CMD = 8'hE1;
  localparam logic [3:0] DECOM_LEN = 4'hC;
  localparam logic [1:0] HELD_ADVANCE = 2'h2;
  localparam logic [31:0] LFSR_RESET = 32'hACE1_2468;
  localparam logic [31:0] SEQ_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    ZGCS_LIST_CURRENT,
    ZGCS_LIST_PRIMARY,
    ZGCS_LIST_ALL
  } zgcs_list_t;

  typedef enum logic [1:0] {
    ZGCS_TG_DATA,
    ZGCS_TG_COMMISSION,
    ZGCS_TG_DECOMMISSION
  } zgcs_tg_kind_t;

  typedef struct packed {
    zgcs_tg_kind_t kind;
    logic [4:0] channel;
    logic [7:0] data;
    logic last;
  } zgcs_tx_beat_t;
endpackage : zgcs_pkg

//--- verilog/zgcs_ctrl.sv
// Notes on behaviour
// - Decommission telegram only on a register request, never from button or harvester.
// - Decommission payload is exactly twelve bytes.
// - Order: 0x8C, 0x30, source address, sequence count, 0xE1, signature.
// - After sending a decommission telegram the link key becomes a fresh random value.
// - Data telegrams carry a signature made with the current link key.
// - Any channel 11 to 26 may be the operating channel.
// - A channel written by software is used for later telegrams unless a manual channel step falls in the same cycle.
// - Button held during a harvester action enters manual channel selection.
// - Manual selection sends commissioning telegrams, on successive channels from the third held action unless the list is current only.
// - The last selected channel stays until a software write or a later manual channel step changes it.
// - Channel changes only when the button is held for three or more actions.
// - Manual selection is ignored while the button-selection disable bit is set.
// - Each manual sequence starts on the current channel.
// - List setting: current only, four primary, or all; all is default.
// - Current-only list keeps every commissioning telegram on one channel.
// - Primary list steps 11, 15, 20, 25 and wraps to 11.
// - All list steps 11 to 26 one by one and wraps to 11.
module zgcs_ctrl #(
  parameter logic [4:0] RESET_CHANNEL = 5'h0B,
  parameter logic [31:0] RESET_SRC_ADDR = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] RESET_KEY = 32'h1234_5678
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic commission_button,
  input wire logic harvest_action,
  input wire logic [31:0] auth_signature,
  output logic [31:0] link_security_key,
  output zgcs_pkg::zgcs_tx_beat_t tx_beat,
  output logic tx_valid,
  input wire logic tx_ready
);
  import zgcs_pkg::*;

  typedef enum logic {ZGCS_IDLE, ZGCS_STREAM} zgcs_state_t;

  function automatic logic [4:0] zgcs_next_channel(input zgcs_list_t list, input logic [4:0] ch);
    logic [4:0] nx;
    nx = ch;
    case (list)
      ZGCS_LIST_CURRENT: nx = ch;
      ZGCS_LIST_PRIMARY: begin
        if (ch < CH_PRI_2) nx = CH_PRI_2;
        else if (ch < CH_PRI_3) nx = CH_PRI_3;
        else if (ch < CH_PRI_4) nx = CH_PRI_4;
        else nx = CH_PRI_1;
      end
      ZGCS_LIST_ALL: nx = (ch >= CH_LAST) ? CH_FIRST : ch + 5'h01;
      default: nx = ch;
    endcase
    return nx;
  endfunction : zgcs_next_channel

  function automatic logic [7:0] zgcs_decom_byte(input logic [3:0] idx, input logic [31:0] src,
                                                 input logic [31:0] seq, input logic [31:0] sig);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      4'h0: b = DECOM_FC;
      4'h1: b = DECOM_EXT_FC;
      4'h2: b = src[7:0];
      4'h3: b = src[15:8];
      4'h4: b = src[23:16];
      4'h5: b = src[31:24];
      4'h6: b = seq[7:0];
      4'h7: b = DECOM_CMD;
      4'h8: b = sig[7:0];
      4'h9: b = sig[15:8];
      4'hA: b = sig[23:16];
      4'hB: b = sig[31:24];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : zgcs_decom_byte

  logic btn_s1_q, btn_s2_q, hv_s1_q, hv_s2_q, hv_s3_q;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  zgcs_list_t list_q, list_d;
  logic btn_dis_q, btn_dis_d, decom_pend_q, decom_pend_d, manual_q, manual_d;
  logic [4:0] chan_q, chan_d;
  logic [31:0] src_q, src_d, seq_q, seq_d, key_q, key_d, lfsr_q, lfsr_d, sig_q, sig_d;
  logic [1:0] held_q, held_d;
  logic [3:0] idx_q, idx_d;
  zgcs_state_t state_q, state_d;
  zgcs_tx_beat_t beat_q, beat_d;
  logic txv_q, txv_d;
  logic harvest_edge, wr_fire, decom_wr;

  assign harvest_edge = hv_s2_q & ~hv_s3_q;
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link_security_key = key_q;
  assign tx_beat = beat_q;
  assign tx_valid = txv_q;
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign decom_wr = wr_fire & (awaddr_q == ADDR_CTRL) & wdata_q[CTRL_DECOM_BIT];

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    list_d = list_q;
    btn_dis_d = btn_dis_q;
    chan_d = chan_q;
    src_d = src_q;
    decom_pend_d = decom_pend_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awaddr_q)
        ADDR_CTRL: begin
          if (wdata_q[CTRL_LIST_LSB +: 2] <= 2'(ZGCS_LIST_ALL))
            list_d = zgcs_list_t'(wdata_q[CTRL_LIST_LSB +: 2]);
          btn_dis_d = wdata_q[CTRL_BTN_DIS_BIT];
        end
        ADDR_CHANNEL: begin
          if (wdata_q[4:0] >= CH_FIRST && wdata_q[4:0] <= CH_LAST)
            chan_d = wdata_q[4:0];
        end
        ADDR_SRC: src_d = wdata_q;
        ADDR_STATUS, ADDR_SEQ: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_d = {29'h0, btn_dis_q, list_q};
        ADDR_CHANNEL: rdata_d = {27'h0, chan_q};
        ADDR_STATUS: rdata_d = {28'h0, held_q, manual_q, decom_pend_q | (state_q == ZGCS_STREAM)};
        ADDR_SRC: rdata_d = src_q;
        ADDR_SEQ: rdata_d = seq_q;
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    // Harvester channel steps below override a same-cycle software write
    manual_d = manual_q;
    held_d = held_q;
    state_d = state_q;
    idx_d = idx_q;
    beat_d = beat_q;
    txv_d = txv_q;
    seq_d = seq_q;
    key_d = key_q;
    sig_d = sig_q;
    lfsr_d = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    if (decom_wr) decom_pend_d = 1'b1;
    case (state_q)
      ZGCS_IDLE: begin
        if (txv_q && tx_ready) txv_d = 1'b0;
        if (!txv_q || tx_ready) begin
          if (harvest_edge) begin
            txv_d = 1'b1;
            seq_d = seq_q + 32'h1;
            beat_d.last = 1'b1;
            beat_d.data = 8'h00;
            if (btn_s2_q && !btn_dis_q) begin
              manual_d = 1'b1;
              beat_d.kind = ZGCS_TG_COMMISSION;
              if (held_q == HELD_ADVANCE) begin
                chan_d = zgcs_next_channel(list_q, chan_q);
                beat_d.channel = chan_d;
              end else begin
                held_d = held_q + 2'h1;
                beat_d.channel = chan_q;
              end
            end else begin
              // Any other action ends the sequence; channel stays put
              manual_d = 1'b0;
              held_d = 2'h0;
              beat_d.kind = ZGCS_TG_DATA;
              beat_d.channel = chan_q;
              beat_d.data = auth_signature[7:0];
            end
          end else if (decom_pend_q) begin
            // Signature latched once so all bytes belong to one frame
            decom_pend_d = decom_wr;
            sig_d = auth_signature;
            state_d = ZGCS_STREAM;
            idx_d = 4'h0;
            txv_d = 1'b1;
            beat_d.kind = ZGCS_TG_DECOMMISSION;
            beat_d.channel = chan_q;
            beat_d.data = zgcs_decom_byte(4'h0, src_q, seq_q, auth_signature);
            beat_d.last = 1'b0;
          end
        end
      end
      ZGCS_STREAM: begin
        if (tx_ready) begin
          if (idx_q == DECOM_LEN - 4'h1) begin
            state_d = ZGCS_IDLE;
            txv_d = 1'b0;
            seq_d = seq_q + 32'h1;
            key_d = lfsr_q;
          end else begin
            idx_d = idx_q + 4'h1;
            beat_d.data = zgcs_decom_byte(idx_d, src_q, seq_q, sig_q);
            beat_d.last = (idx_d == DECOM_LEN - 4'h1);
          end
        end
      end
      default: state_d = ZGCS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      hv_s1_q <= 1'b0;
      hv_s2_q <= 1'b0;
      hv_s3_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
      list_q <= ZGCS_LIST_ALL;
      btn_dis_q <= 1'b0;
      chan_q <= RESET_CHANNEL;
      src_q <= RESET_SRC_ADDR;
      decom_pend_q <= 1'b0;
      manual_q <= 1'b0;
      held_q <= 2'h0;
      state_q <= ZGCS_IDLE;
      idx_q <= 4'h0;
      beat_q <= '0;
      txv_q <= 1'b0;
      seq_q <= SEQ_RESET;
      key_q <= RESET_KEY;
      sig_q <= 32'h0;
      lfsr_q <= LFSR_RESET;
    end else begin
      btn_s1_q <= commission_button;
      btn_s2_q <= btn_s1_q;
      hv_s1_q <= harvest_action;
      hv_s2_q <= hv_s1_q;
      hv_s3_q <= hv_s2_q;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      list_q <= list_d;
      btn_dis_q <= btn_dis_d;
      chan_q <= chan_d;
      src_q <= src_d;
      decom_pend_q <= decom_pend_d;
      manual_q <= manual_d;
      held_q <= held_d;
      state_q <= state_d;
      idx_q <= idx_d;
      beat_q <= beat_d;
      txv_q <= txv_d;
      seq_q <= seq_d;
      key_q <= key_d;
      sig_q <= sig_d;
      lfsr_q <= lfsr_d;
    end
  end
endmodule : zgcs_ctrl

//--- bench/zgcs_ctrl_properties.sv
module zgcs_ctrl_properties (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] link_security_key,
  input wire zgcs_pkg::zgcs_tx_beat_t tx_beat,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import zgcs_pkg::*;
  logic [3:0] dcnt_q, dcnt_d;
  logic dbeat, dend;
  assign dbeat = tx_valid && tx_beat.kind == ZGCS_TG_DECOMMISSION;
  assign dend = dbeat && tx_ready && tx_beat.last;
  // Byte index within the decommission telegram
  always_comb begin
    dcnt_d = dcnt_q;
    if (dbeat && tx_ready) begin
      dcnt_d = tx_beat.last ? 4'h0 : dcnt_q + 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    dcnt_q <= rst_b ? dcnt_d : 4'h0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_decom_end;
    dend;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_beat_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
    else $error("tx beat dropped or changed while stalled");
  chk_chan_range: assert property (tx_valid |-> tx_beat.channel inside {[CH_FIRST:CH_LAST]})
    else $error("channel outside 11 to 26");
  chk_decom_head: assert property (dbeat && dcnt_q == 4'h0 |-> tx_beat.data == DECOM_FC)
    else $error("decommission first byte wrong");
  chk_decom_cmd: assert property (dbeat && dcnt_q == 4'h7 |-> tx_beat.data == DECOM_CMD)
    else $error("decommission command byte wrong");
  chk_decom_len: assert property (dbeat |-> tx_beat.last == (dcnt_q == 4'hB))
    else $error("decommission length not twelve");
  chk_key_renew: assert property (s_decom_end |=> link_security_key != $past(link_security_key))
    else $error("key not renewed after decommission");
  chk_key_hold: assert property (!dend |=> $stable(link_security_key))
    else $error("key changed without decommission");
  // Both halves are parked one cycle before the response is raised
  chk_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : zgcs_ctrl_properties

//--- bench/zgcs_radio_model.sv
module zgcs_radio_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire zgcs_pkg::zgcs_tx_beat_t tx_beat,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic rx_fire,
  output zgcs_pkg::zgcs_tx_beat_t rx_beat
);
  timeunit 1ns;
  timeprecision 100ps;
  import zgcs_pkg::*;
  // Random stalls so held beats get exercised
  always @(posedge clock) tx_ready <= rst_b && ($urandom % 3 != 0);
  assign rx_fire = tx_valid && tx_ready;
  assign rx_beat = tx_beat;
endmodule : zgcs_radio_model

//--- bench/tb_zgcs_ctrl.sv
module tb_zgcs_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import zgcs_pkg::*;
  logic clock, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic commission_button, harvest_action, tx_valid, tx_ready, rx_fire;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, auth_signature, link_security_key;
  logic [31:0] seq_cnt, key_old, src;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  zgcs_tx_beat_t tx_beat, rx_beat, e, m;
  zgcs_tx_beat_t exp_q[$];
  int error_cnt, checks_done;
  // Columns: ctrl, start channel, then expected channel per held action
  logic [4:0] tbl [5][6] = '{'{5'h02, 5'h0B, 5'h0B, 5'h0B, 5'h0C, 5'h0D},
    '{5'h02, 5'h1A, 5'h1A, 5'h1A, 5'h0B, 5'h0C}, '{5'h01, 5'h14, 5'h14, 5'h14, 5'h19, 5'h0B},
    '{5'h00, 5'h0D, 5'h0D, 5'h0D, 5'h0D, 5'h0D}, '{5'h06, 5'h0F, 5'h0F, 5'h0F, 5'h0F, 5'h0F}};
  zgcs_ctrl zgcs_ctrl_inst (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .commission_button, .harvest_action, .auth_signature,
    .link_security_key, .tx_beat, .tx_valid, .tx_ready);
  zgcs_radio_model zgcs_radio_model_inst (.clock, .rst_b, .tx_beat, .tx_valid, .tx_ready,
    .rx_fire, .rx_beat);
  always #2 clock = ~clock;
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] s);
    checks_done++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : cmp
  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'($urandom);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    cmp("bresp", 32'(r), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    cmp("rdata", x, s_axi_rdata);
    cmp("rresp", 32'(r), 32'(s_axi_rresp));
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic idle();
    while (exp_q.size() != 0) @(posedge clock);
    repeat (4) @(posedge clock);
  endtask : idle
  // Next action only once the slot is free, else the design drops it
  task automatic act(input logic b, input logic cm, input logic [4:0] ch);
    @(posedge clock);
    commission_button <= b;
    auth_signature <= $urandom;
    repeat (4) @(posedge clock);
    harvest_action <= 1'b1;
    e.kind = cm ? ZGCS_TG_COMMISSION : ZGCS_TG_DATA;
    e.channel = ch;
    e.data = auth_signature[7:0];
    e.last = 1'b1;
    exp_q.push_back(e);
    seq_cnt++;
    repeat (4) @(posedge clock);
    harvest_action <= 1'b0;
    idle();
  endtask : act
  always @(posedge clock) begin
    if (rst_b && rx_fire) begin
      if (exp_q.size() == 0) begin
        cmp("unexpected beat", 32'h0, 32'h1);
      end else begin
        m = exp_q.pop_front();
        cmp("kind", 32'(m.kind), 32'(rx_beat.kind));
        cmp("channel", 32'(m.channel), 32'(rx_beat.channel));
        if (m.kind != ZGCS_TG_COMMISSION) cmp("data", 32'(m.data), 32'(rx_beat.data));
        if (m.kind == ZGCS_TG_DECOMMISSION) cmp("last", 32'(m.last), 32'(rx_beat.last));
      end
    end
  end
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
    {commission_button, harvest_action, s_axi_wdata, auth_signature} = 66'h0;
    {error_cnt, checks_done, seq_cnt} = 96'h0;
    void'($urandom(32'h4C103D49));
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    axi_rd(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
    axi_rd(ADDR_CHANNEL, 32'h0000_000B, RESP_OKAY);
    act(1'b0, 1'b0, CH_FIRST);
    for (int i = 0; i < 5; i++) begin
      axi_wr(ADDR_CTRL, 32'(tbl[i][0]), RESP_OKAY);
      axi_wr(ADDR_CHANNEL, 32'(tbl[i][1]), RESP_OKAY);
      for (int j = 2; j < 6; j++) act(1'b1, tbl[i][0] < 5'h04, tbl[i][j]);
      act(1'b0, 1'b0, tbl[i][5]);
      axi_rd(ADDR_CHANNEL, 32'(tbl[i][5]), RESP_OKAY);
    end
    axi_wr(ADDR_CHANNEL, 32'h0000_001B, RESP_OKAY);
    axi_rd(ADDR_CHANNEL, 32'h0000_000F, RESP_OKAY);
    axi_wr(8'h14, 32'h0000_0000, RESP_SLVERR);
    axi_rd(8'h14, 32'h0000_0000, RESP_SLVERR);
    src = $urandom;
    axi_wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
    axi_wr(ADDR_SRC, src, RESP_OKAY);
    auth_signature <= $urandom;
    @(posedge clock);
    key_old = link_security_key;
    for (int k = 0; k < 12; k++) begin
      e.kind = ZGCS_TG_DECOMMISSION;
      e.channel = 5'h0F;
      e.last = k == 11;
      e.data = k == 0 ? DECOM_FC : k == 1 ? DECOM_EXT_FC : k < 6 ? src[8*(k-2) +: 8] :
        k == 6 ? seq_cnt[7:0] : k == 7 ? DECOM_CMD : auth_signature[8*(k-8) +: 8];
      exp_q.push_back(e);
    end
    axi_wr(ADDR_CTRL, 32'h0000_000A, RESP_OKAY);
    idle();
    cmp("key renewed", 32'h0, 32'(link_security_key === key_old));
    seq_cnt++;
    axi_rd(ADDR_SEQ, seq_cnt, RESP_OKAY);
    act(1'b0, 1'b0, 5'h0F);
    summarize();
  end
endmodule : tb_zgcs_ctrl
bind zgcs_ctrl zgcs_ctrl_properties zgcs_ctrl_properties_inst (.clock, .rst_b, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .link_security_key, .tx_beat, .tx_valid, .tx_ready);
